// ==== src/pin_mux_pkg.sv ====
package pin_mux_pkg;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [7:0] SEL_BASE_OFS = 8'h00;
   localparam int SEL_COUNT = 10;
   localparam logic [7:0] PORT_D_UPPER_SELECT_OFS = 8'h0c;
   localparam logic [7:0] IFS_TIMER_OFS = 8'h28;
   localparam logic [7:0] IFS_SERIAL_OFS = 8'h2c;
   localparam logic [7:0] IFS_TIMER_B_OFS = 8'h30;
   localparam logic [7:0] IFS_UART_OFS = 8'h34;
   localparam logic [7:0] KEY_OFS = 8'h38;
   localparam logic [7:0] PORT_READ_BASE_OFS = 8'h40;
   localparam int PORT_READ_COUNT = 5;

   // Implemented bit masks
   localparam logic [7:0] PORT_D_UPPER_SELECT_MASK = 8'h3f;
   localparam logic [7:0] IFS_TIMER_MASK = 8'h7f;
   localparam logic [7:0] IFS_SERIAL_MASK = 8'h7f;
   localparam logic [7:0] IFS_TIMER_B_MASK = 8'hff;
   localparam logic [7:0] IFS_UART_MASK = 8'h03;

   // Values after reset, and the read-port key
   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [7:0] KEY_RESET = 8'h00;
   localparam logic [7:0] READ_PORT_KEY = 8'hca;

   // Pin numbering of the synchronised pin vector, ports A to G
   localparam int PIN_A = 0;
   localparam int PIN_B = 8;
   localparam int PIN_C = 16;
   localparam int PIN_D = 24;
   localparam int PIN_E = 32;
   localparam int PIN_F = 40;
   localparam int PIN_G = 48;
   localparam int MUX_PINS = 40;
   localparam int ANALOG_CHANNELS = 10;

   // Function classes of a shared pin
   typedef enum logic [2:0] {
      FN_GPIO = 3'h0,
      FN_DIG = 3'h1,
      FN_ANA = 3'h2,
      FN_LCD = 3'h3,
      FN_RSV = 3'h4,
      FN_SPC = 3'h5
   } pin_fn_e;

   // Per pin, classes for codes {11,10,01,00}; pins C0..C7, D0..D7, E, F, G
   localparam logic [11:0] PIN_FN_TABLE [MUX_PINS] = '{
      {FN_LCD, FN_ANA, FN_SPC, FN_GPIO}, {FN_DIG, FN_ANA, FN_SPC, FN_GPIO},
      {FN_LCD, FN_DIG, FN_ANA, FN_GPIO}, {FN_LCD, FN_ANA, FN_DIG, FN_GPIO},
      {FN_LCD, FN_DIG, FN_ANA, FN_GPIO}, {FN_LCD, FN_ANA, FN_DIG, FN_GPIO},
      {FN_LCD, FN_DIG, FN_ANA, FN_GPIO}, {FN_LCD, FN_ANA, FN_DIG, FN_GPIO},
      {FN_LCD, FN_ANA, FN_DIG, FN_GPIO}, {FN_LCD, FN_ANA, FN_DIG, FN_GPIO},
      {FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO}, {FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
      {FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO}, {FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
      {FN_LCD, FN_RSV, FN_DIG, FN_GPIO}, {FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
      {FN_LCD, FN_RSV, FN_GPIO, FN_GPIO}, {FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
      {FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO}, {FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
      {FN_SPC, FN_GPIO, FN_GPIO, FN_GPIO}, {FN_LCD, FN_RSV, FN_GPIO, FN_GPIO},
      {FN_LCD, FN_RSV, FN_GPIO, FN_GPIO}, {FN_LCD, FN_RSV, FN_GPIO, FN_GPIO},
      {FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO}, {FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
      {FN_LCD, FN_DIG, FN_GPIO, FN_GPIO}, {FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
      {FN_SPC, FN_GPIO, FN_GPIO, FN_GPIO}, {FN_SPC, FN_DIG, FN_GPIO, FN_GPIO},
      {FN_LCD, FN_SPC, FN_DIG, FN_GPIO}, {FN_SPC, FN_DIG, FN_DIG, FN_GPIO},
      {FN_LCD, FN_GPIO, FN_GPIO, FN_GPIO}, {FN_LCD, FN_GPIO, FN_GPIO, FN_GPIO},
      {FN_LCD, FN_GPIO, FN_GPIO, FN_GPIO}, {FN_LCD, FN_GPIO, FN_GPIO, FN_GPIO},
      {FN_LCD, FN_LCD, FN_GPIO, FN_GPIO}, {FN_LCD, FN_LCD, FN_GPIO, FN_GPIO},
      {FN_LCD, FN_LCD, FN_GPIO, FN_GPIO}, {FN_LCD, FN_LCD, FN_GPIO, FN_GPIO}
   };

endpackage

// ==== src/pin_function_select.sv ====
// Notes on behaviour
// - C0 codes: I/O, reference in, AN0, LCD_SEGMENT_42
// - C7 codes: I/O/irq3/timer clock, PTIMER6_OUTPUT, AN7, SEG36
// - C4, C6 codes: I/O, analog, timer, segment; C5 codes: I/O, timer, analog, segment
// - D1 codes: I/O/timer clock, UART, AN9, SEG34
// - D0 codes: I/O/irq2, timer out, AN8, SEG35
// - D6 codes: I/O, timer out, reserved, SEG27
// - E0 codes: I/O twice, reserved, SEG7
// - E5-E7 codes: I/O twice, reserved, segment
// - E4 code 11 selects alternate supply
// - F2 codes: I/O twice, serial in, SEG11
// - F4-F7 codes: I/O, timer, UART, comparator, crystal
// - G0-G3 code 11 gives common lines
// - G4-G7: common on 10, segment on 11
// - Timer clock inputs routed from chosen pin, except ptimer_clk_out[4] and [5], which stay low
// - Interrupt inputs routed from chosen pin
// - Serial and UART receive routed from chosen pin
// - Unimplemented bits read zero, ignore writes
// - Key 0xca sets read-port mode, else clears
// - Mode on reads pins, off reads latch
// - Mode touches only the read path and the selected analog path
// - Mode forces selected analog channel path on
`timescale 1ns/1ns
module pin_function_select (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [7:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   input wire logic [7:0] port_a_pins_in,
   input wire logic [7:0] port_b_pins_in,
   input wire logic [7:0] port_c_pins_in,
   input wire logic [7:0] port_d_pins_in,
   input wire logic [7:0] port_e_pins_in,
   input wire logic [7:0] port_f_pins_in,
   input wire logic [7:0] port_g_pins_in,
   input wire logic [7:0] port_c_latch_in,
   input wire logic [7:0] port_d_latch_in,
   input wire logic [7:0] port_e_latch_in,
   input wire logic [7:0] port_f_latch_in,
   input wire logic [7:0] port_g_latch_in,
   input wire logic [3:0] adc_channel_in,
   output logic [pin_mux_pkg::MUX_PINS-1:0] gpio_mode_out,
   output logic [pin_mux_pkg::MUX_PINS-1:0] alt_digital_out,
   output logic [pin_mux_pkg::MUX_PINS-1:0] analog_pin_out,
   output logic [pin_mux_pkg::MUX_PINS-1:0] lcd_pin_out,
   output logic [pin_mux_pkg::MUX_PINS-1:0] special_pin_out,
   output logic [pin_mux_pkg::MUX_PINS-1:0] reserved_pin_out,
   output logic [pin_mux_pkg::ANALOG_CHANNELS-1:0] analog_path_out,
   output logic [2:0] stimer_clk_out,
   output logic [7:0] ptimer_clk_out,
   output logic [3:0] irq_out,
   output logic sdi_out,
   output logic sck_out,
   output logic scs_out,
   output logic [1:0] uart_rx_out,
   output logic read_port_mode_flag_out
);
   import pin_mux_pkg::*;

   logic [7:0] sel_reg [SEL_COUNT];
   logic [7:0] timer_clock_input_route_reg;
   logic [7:0] serial_irq_input_route_reg;
   logic [7:0] timer_clock_input_route_b_reg;
   logic [7:0] uart_rx_input_route_reg;
   logic [7:0] read_port_key_reg;
   logic read_port_mode_flag_reg;
   logic waitrequest_reg;
   logic [31:0] readdata_reg;
   logic [55:0] pin_sync1_reg;
   logic [55:0] pin_sync2_reg;
   logic [31:0] readdata_next;
   logic [7:0] word_ofs;
   logic [7:0] wbyte;
   logic wr_take;
   logic [2*MUX_PINS-1:0] sel_all;
   logic [39:0] port_latch_all;
   logic [39:0] port_read_all;

   // Class of a pin for a given selector code
   function automatic logic [2:0] pin_class(input int pin,
                                            input logic [1:0] code);
      logic [11:0] entry;
      entry = PIN_FN_TABLE[pin];
      case (code)
         2'h0: pin_class = entry[2:0];
         2'h1: pin_class = entry[5:3];
         2'h2: pin_class = entry[8:6];
         default: pin_class = entry[11:9];
      endcase
   endfunction

   // Two-way source pick; a reserved choice delivers a quiet low
   function automatic logic pick(input logic s, input logic pin0,
                                 input logic pin1, input logic ok0,
                                 input logic ok1);
      if (s) begin
         pick = pin1 & ok1;
      end else begin
         pick = pin0 & ok0;
      end
   endfunction

   assign word_ofs = {address_in[7:2], 2'h0};
   assign wbyte = writedata_in[7:0];
   assign wr_take = write_in && !waitrequest_reg && byteenable_in[0];
   assign waitrequest_out = waitrequest_reg;
   assign readdata_out = readdata_reg;
   assign read_port_mode_flag_out = read_port_mode_flag_reg;

   // Pins pass two flip-flops before anything reads them
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_sync1_reg <= '0;
         pin_sync2_reg <= '0;
      end else begin
         pin_sync1_reg <= {port_g_pins_in, port_f_pins_in, port_e_pins_in,
                           port_d_pins_in, port_c_pins_in, port_b_pins_in,
                           port_a_pins_in};
         pin_sync2_reg <= pin_sync1_reg;
      end
   end

   // One wait state, then a single answer cycle
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         waitrequest_reg <= 1'b1;
      end else if ((read_in || write_in) && waitrequest_reg) begin
         waitrequest_reg <= 1'b0;
      end else begin
         waitrequest_reg <= 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         readdata_reg <= '0;
      end else if (read_in && waitrequest_reg) begin
         readdata_reg <= readdata_next;
      end
   end

   // Pin selector registers, written only in implemented bits
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < SEL_COUNT; i++) begin
            sel_reg[i] <= SEL_RESET;
         end
      end else if (wr_take && address_in[7:2] < 6'(SEL_COUNT)) begin
         if (word_ofs == PORT_D_UPPER_SELECT_OFS) begin
            sel_reg[address_in[5:2]] <= wbyte & PORT_D_UPPER_SELECT_MASK;
         end else begin
            sel_reg[address_in[5:2]] <= wbyte;
         end
      end
   end

   // Input source routing registers
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         timer_clock_input_route_reg <= SEL_RESET;
         serial_irq_input_route_reg <= SEL_RESET;
         timer_clock_input_route_b_reg <= SEL_RESET;
         uart_rx_input_route_reg <= SEL_RESET;
      end else if (wr_take) begin
         case (word_ofs)
            IFS_TIMER_OFS: begin
               timer_clock_input_route_reg <= wbyte & IFS_TIMER_MASK;
            end
            IFS_SERIAL_OFS: begin
               serial_irq_input_route_reg <= wbyte & IFS_SERIAL_MASK;
            end
            IFS_TIMER_B_OFS: begin
               timer_clock_input_route_b_reg <= wbyte & IFS_TIMER_B_MASK;
            end
            IFS_UART_OFS: begin
               uart_rx_input_route_reg <= wbyte & IFS_UART_MASK;
            end
            default: begin
            end
         endcase
      end
   end

   // Key register and the read-port mode it controls
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         read_port_key_reg <= KEY_RESET;
         read_port_mode_flag_reg <= 1'b0;
      end else if (wr_take && word_ofs == KEY_OFS) begin
         read_port_key_reg <= wbyte;
         read_port_mode_flag_reg <= (wbyte == READ_PORT_KEY);
      end
   end

   always_comb begin
      sel_all = '0;
      for (int i = 0; i < SEL_COUNT; i++) begin
         sel_all[8*i +: 8] = sel_reg[i];
      end
   end

   assign port_latch_all = {port_g_latch_in, port_f_latch_in,
                            port_e_latch_in, port_d_latch_in,
                            port_c_latch_in};

   // Port read path: live pins in read-port mode, else the latch
   always_comb begin
      if (read_port_mode_flag_reg) begin
         port_read_all = pin_sync2_reg[55:16];
      end else begin
         port_read_all = port_latch_all;
      end
   end

   // Register read mux; unmapped and unimplemented bits read zero
   always_comb begin
      readdata_next = '0;
      if (address_in[7:2] < 6'(SEL_COUNT)) begin
         readdata_next[7:0] = sel_reg[address_in[5:2]];
      end else if (word_ofs >= PORT_READ_BASE_OFS &&
                   address_in[7:2] < 6'(PORT_READ_BASE_OFS[7:2] +
                                        6'(PORT_READ_COUNT))) begin
         case (address_in[4:2])
            3'h0: readdata_next[7:0] = port_read_all[7:0];
            3'h1: readdata_next[7:0] = port_read_all[15:8];
            3'h2: readdata_next[7:0] = port_read_all[23:16];
            3'h3: readdata_next[7:0] = port_read_all[31:24];
            default: readdata_next[7:0] = port_read_all[39:32];
         endcase
      end else begin
         case (word_ofs)
            IFS_TIMER_OFS: readdata_next[7:0] = timer_clock_input_route_reg;
            IFS_SERIAL_OFS: readdata_next[7:0] = serial_irq_input_route_reg;
            IFS_TIMER_B_OFS: begin
               readdata_next[7:0] = timer_clock_input_route_b_reg;
            end
            IFS_UART_OFS: readdata_next[7:0] = uart_rx_input_route_reg;
            KEY_OFS: readdata_next[7:0] = read_port_key_reg;
            default: readdata_next = '0;
         endcase
      end
   end

   // Pin function decode, registered so a change lands next cycle
   // and pins whose code did not change keep a steady level
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gpio_mode_out <= {MUX_PINS{1'b1}};
         alt_digital_out <= '0;
         analog_pin_out <= '0;
         lcd_pin_out <= '0;
         special_pin_out <= '0;
         reserved_pin_out <= '0;
      end else begin
         for (int i = 0; i < MUX_PINS; i++) begin
            gpio_mode_out[i] <= pin_class(i, sel_all[2*i +: 2]) == FN_GPIO;
            alt_digital_out[i] <= pin_class(i, sel_all[2*i +: 2]) == FN_DIG;
            analog_pin_out[i] <= pin_class(i, sel_all[2*i +: 2]) == FN_ANA;
            lcd_pin_out[i] <= pin_class(i, sel_all[2*i +: 2]) == FN_LCD;
            special_pin_out[i] <= pin_class(i, sel_all[2*i +: 2]) == FN_SPC;
            reserved_pin_out[i] <= pin_class(i, sel_all[2*i +: 2]) == FN_RSV;
         end
      end
   end

   // Analog path per channel; channel n sits on mux pin n
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         analog_path_out <= '0;
      end else begin
         for (int i = 0; i < ANALOG_CHANNELS; i++) begin
            analog_path_out[i] <=
               (pin_class(i, sel_all[2*i +: 2]) == FN_ANA) ||
               (read_port_mode_flag_reg &&
                adc_channel_in == 4'(i));
         end
      end
   end

   // Timer clock input routing
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stimer_clk_out <= '0;
         ptimer_clk_out <= '0;
      end else begin
         stimer_clk_out[0] <= pick(timer_clock_input_route_reg[0],
            pin_sync2_reg[PIN_C+7], pin_sync2_reg[PIN_E+0], 1'b1, 1'b1);
         stimer_clk_out[1] <= pick(timer_clock_input_route_reg[1],
            pin_sync2_reg[PIN_D+1], pin_sync2_reg[PIN_B+7], 1'b1, 1'b1);
         stimer_clk_out[2] <= pick(timer_clock_input_route_reg[2],
            pin_sync2_reg[PIN_F+6], pin_sync2_reg[PIN_B+0], 1'b1, 1'b1);
         ptimer_clk_out[0] <= pick(timer_clock_input_route_reg[3],
            pin_sync2_reg[PIN_C+3], pin_sync2_reg[PIN_F+4], 1'b1, 1'b1);
         ptimer_clk_out[1] <= pick(timer_clock_input_route_reg[4],
            pin_sync2_reg[PIN_C+5], 1'b0, 1'b1, 1'b0);
         ptimer_clk_out[2] <= pick(timer_clock_input_route_reg[5],
            1'b0, pin_sync2_reg[PIN_B+2], 1'b0, 1'b1);
         ptimer_clk_out[3] <= pick(timer_clock_input_route_reg[6],
            1'b0, pin_sync2_reg[PIN_B+1], 1'b0, 1'b1);
         ptimer_clk_out[4] <= 1'b0;
         ptimer_clk_out[5] <= 1'b0;
         ptimer_clk_out[6] <= pick(timer_clock_input_route_b_reg[6],
            pin_sync2_reg[PIN_F+2], pin_sync2_reg[PIN_C+2], 1'b1, 1'b1);
         ptimer_clk_out[7] <= pick(timer_clock_input_route_b_reg[7],
            1'b0, pin_sync2_reg[PIN_C+4], 1'b0, 1'b1);
      end
   end

   // Interrupt, serial and UART receive input routing
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_out <= '0;
         sdi_out <= 1'b0;
         sck_out <= 1'b0;
         scs_out <= 1'b0;
         uart_rx_out <= '0;
      end else begin
         irq_out[0] <= pick(serial_irq_input_route_reg[0],
            pin_sync2_reg[PIN_A+1], pin_sync2_reg[PIN_A+6], 1'b1, 1'b1);
         irq_out[1] <= pick(serial_irq_input_route_reg[1],
            pin_sync2_reg[PIN_A+3], pin_sync2_reg[PIN_A+7], 1'b1, 1'b1);
         irq_out[2] <= pick(serial_irq_input_route_reg[2],
            pin_sync2_reg[PIN_A+4], pin_sync2_reg[PIN_D+0], 1'b1, 1'b1);
         irq_out[3] <= pick(serial_irq_input_route_reg[3],
            pin_sync2_reg[PIN_A+5], pin_sync2_reg[PIN_C+7], 1'b1, 1'b1);
         sck_out <= pick(serial_irq_input_route_reg[4],
            pin_sync2_reg[PIN_A+5], 1'b0, 1'b1, 1'b0);
         sdi_out <= pick(serial_irq_input_route_reg[5],
            pin_sync2_reg[PIN_A+4], pin_sync2_reg[PIN_F+2], 1'b1, 1'b1);
         scs_out <= pick(serial_irq_input_route_reg[6],
            pin_sync2_reg[PIN_A+1], 1'b0, 1'b1, 1'b0);
         uart_rx_out[0] <= pick(uart_rx_input_route_reg[0],
            pin_sync2_reg[PIN_A+6], 1'b0, 1'b1, 1'b0);
         uart_rx_out[1] <= pick(uart_rx_input_route_reg[1],
            pin_sync2_reg[PIN_D+1], pin_sync2_reg[PIN_F+6], 1'b1, 1'b1);
      end
   end

endmodule

// ==== tb/pin_function_select_sva.sv ====
`timescale 1ns/1ns
module pin_function_select_sva (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [7:0] address_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   input wire logic [31:0] readdata_out,
   input wire logic waitrequest_out,
   input wire logic [3:0] adc_channel_in,
   input wire logic [pin_mux_pkg::MUX_PINS-1:0] gpio_mode_out,
   input wire logic [pin_mux_pkg::MUX_PINS-1:0] alt_digital_out,
   input wire logic [pin_mux_pkg::MUX_PINS-1:0] analog_pin_out,
   input wire logic [pin_mux_pkg::MUX_PINS-1:0] lcd_pin_out,
   input wire logic [pin_mux_pkg::MUX_PINS-1:0] special_pin_out,
   input wire logic [pin_mux_pkg::MUX_PINS-1:0] reserved_pin_out,
   input wire logic [pin_mux_pkg::ANALOG_CHANNELS-1:0] analog_path_out,
   input wire logic read_port_mode_flag_out
);
   import pin_mux_pkg::*;
   logic key_wr;
   logic [15:0] ch_hot;
   assign key_wr = write_in && !waitrequest_out && byteenable_in[0]
      && address_in[7:2] == KEY_OFS[7:2];
   assign ch_hot = 16'h0001 << adc_channel_in;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   AST_KEY_SET:
      assert property (key_wr && writedata_in[7:0] == READ_PORT_KEY
         |=> read_port_mode_flag_out) else $error("key did not set mode");
   AST_KEY_CLR:
      assert property (key_wr && writedata_in[7:0] != READ_PORT_KEY
         |=> !read_port_mode_flag_out) else $error("mode kept by bad key");
   AST_MODE_CAUSE:
      assert property (!$stable(read_port_mode_flag_out) |-> $past(key_wr))
      else $error("mode changed without key write");
   AST_PATH_FORCE:
      assert property (read_port_mode_flag_out && adc_channel_in < 4'ha
         ##1 $stable(adc_channel_in) |-> |(analog_path_out & ch_hot[9:0]))
      else $error("selected analog path not forced on");
   AST_PATH_OFF:
      assert property (!read_port_mode_flag_out && analog_pin_out[9:0] == '0
         ##1 analog_pin_out[9:0] == '0 |-> analog_path_out == '0)
      else $error("analog path on without cause");
   AST_UPPER_ZERO:
      assert property (!waitrequest_out |-> readdata_out[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   AST_RESET_GPIO:
      assert property ($rose(rst_n_in) |-> gpio_mode_out == '1
         && lcd_pin_out == '0 && !read_port_mode_flag_out)
      else $error("pins not in code 00 after reset");
   AST_DECODE_HOLD:
      assert property (!$stable(lcd_pin_out) || !$stable(gpio_mode_out)
         |-> $past(write_in && !waitrequest_out, 2))
      else $error("pin function changed without write");
   AST_KEY_KEEPS:
      assert property (key_wr |=> $stable(gpio_mode_out)
         && $stable(analog_pin_out)) else $error("key write moved pins");
   AST_ONE_CLASS:
      assert property ((gpio_mode_out ^ alt_digital_out ^ analog_pin_out
         ^ lcd_pin_out ^ special_pin_out ^ reserved_pin_out) == '1)
      else $error("pin without single function");
endmodule
bind pin_function_select pin_function_select_sva chk_u (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .address_in(address_in),
   .write_in(write_in), .writedata_in(writedata_in),
   .byteenable_in(byteenable_in), .readdata_out(readdata_out),
   .waitrequest_out(waitrequest_out), .adc_channel_in(adc_channel_in),
   .gpio_mode_out(gpio_mode_out), .alt_digital_out(alt_digital_out),
   .analog_pin_out(analog_pin_out), .lcd_pin_out(lcd_pin_out),
   .special_pin_out(special_pin_out), .reserved_pin_out(reserved_pin_out),
   .analog_path_out(analog_path_out),
   .read_port_mode_flag_out(read_port_mode_flag_out));

// ==== tb/pin_pad_model.sv ====
`timescale 1ns/1ns
module pin_pad_model (
   input wire logic clock_in,
   input wire logic load_in,
   input wire logic [55:0] level_in,
   output logic [55:0] pins_out
);
   // Outside drivers hold levels; shared input pins are set as inputs
   always_ff @(posedge clock_in) begin
      if (load_in) begin
         pins_out <= level_in;
      end
   end
endmodule

// ==== tb/pin_function_select_tb.sv ====
`timescale 1ns/1ns
module pin_function_select_tb;
   import pin_mux_pkg::*;
   localparam logic [7:0] DEC_ADDR [6] = '{8'h00, 8'h04, 8'h08, 8'h14,
      8'h18, 8'h24};
   localparam int DEC_SH [6] = '{0, 6, 0, 0, 4, 6};
   localparam int DEC_PIN [6] = '{0, 7, 8, 20, 26, 39};
   localparam logic [11:0] DEC_EXP [6] = '{12'h6a8, 12'h688, 12'h688,
      12'ha00, 12'h640, 12'h6c0};
   localparam logic [7:0] RT_ADDR [5] = '{8'h2c, 8'h2c, 8'h34, 8'h28, 8'h28};
   localparam logic [7:0] RT_BASE [5] = '{8'h00, 8'h00, 8'h00, 8'h60, 8'h60};
   localparam int RT_BIT [5] = '{5, 3, 1, 0, 3};
   localparam int RT_P0 [5] = '{4, 5, 25, 23, 19};
   localparam int RT_P1 [5] = '{42, 23, 46, 32, 44};
   localparam logic [7:0] RW_ADDR [6] = '{8'h00, 8'h04, 8'h08, 8'h1c,
      8'h20, 8'h24};
   localparam logic [7:0] UN_ADDR [5] = '{8'h0c, 8'h2c, 8'h34, 8'h28, 8'h30};
   localparam logic [7:0] UN_WR [5] = '{8'hc0, 8'ha0, 8'hfe, 8'he0, 8'h40};
   localparam logic [7:0] UN_RD [5] = '{8'h00, 8'h20, 8'h02, 8'h60, 8'h40};
   localparam logic [7:0] KEYS [4] = '{8'hca, 8'hcb, 8'hca, 8'h4a};
   logic clock_in, rst_n_in, read_in, write_in, waitrequest_out, pin_load;
   logic [7:0] address_in, d;
   logic [31:0] writedata_in, readdata_out, rd, rnd;
   logic [3:0] byteenable_in, adc_channel_in, irq;
   logic [55:0] pin_val, pins, pv;
   logic [39:0] latch, g, gpio_o, alt_o, ana_o, lcd_o, spc_o, rsv_o;
   logic [9:0] apath;
   logic [2:0] st_clk;
   logic [7:0] pt_clk;
   logic [1:0] rx;
   logic sdi, mode, em;
   int n_errors, tests_run, cyc;
   pin_pad_model pad_u (.clock_in(clock_in), .load_in(pin_load),
      .level_in(pin_val), .pins_out(pins));
   pin_function_select dut_u (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .address_in(address_in),
      .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
      .byteenable_in(byteenable_in), .readdata_out(readdata_out),
      .waitrequest_out(waitrequest_out), .port_a_pins_in(pins[7:0]),
      .port_b_pins_in(pins[15:8]), .port_c_pins_in(pins[23:16]),
      .port_d_pins_in(pins[31:24]), .port_e_pins_in(pins[39:32]),
      .port_f_pins_in(pins[47:40]), .port_g_pins_in(pins[55:48]),
      .port_c_latch_in(latch[7:0]), .port_d_latch_in(latch[15:8]),
      .port_e_latch_in(latch[23:16]), .port_f_latch_in(latch[31:24]),
      .port_g_latch_in(latch[39:32]), .adc_channel_in(adc_channel_in),
      .gpio_mode_out(gpio_o), .alt_digital_out(alt_o),
      .analog_pin_out(ana_o), .lcd_pin_out(lcd_o), .special_pin_out(spc_o),
      .reserved_pin_out(rsv_o), .analog_path_out(apath),
      .stimer_clk_out(st_clk), .ptimer_clk_out(pt_clk), .irq_out(irq),
      .sdi_out(sdi), .sck_out(), .scs_out(), .uart_rx_out(rx),
      .read_port_mode_flag_out(mode));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
   endfunction
   function automatic logic [2:0] got_cls(input int p);
      return alt_o[p] ? FN_DIG : ana_o[p] ? FN_ANA : lcd_o[p] ? FN_LCD
         : spc_o[p] ? FN_SPC : rsv_o[p] ? FN_RSV : FN_GPIO;
   endfunction
   function automatic logic route_out(input int k);
      return k == 0 ? sdi : k == 1 ? irq[3] : k == 2 ? rx[1]
         : k == 3 ? st_clk[0] : pt_clk[0];
   endfunction
   task automatic report_and_stop();
      $display("comparisons=%0d mismatches=%0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [7:0] dv, input logic [3:0] be);
      @(posedge clock_in);
      address_in <= a;
      writedata_in <= {24'h0, dv};
      byteenable_in <= be;
      write_in <= wr;
      read_in <= !wr;
      do @(posedge clock_in); while (waitrequest_out !== 1'b0);
      rd = readdata_out;
      write_in <= 1'b0;
      read_in <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, 4'hf);
      chk(rd, {24'h0, e});
   endtask
   task automatic set_pins(input logic [55:0] v);
      @(posedge clock_in);
      pin_val <= v;
      pin_load <= 1'b1;
      @(posedge clock_in);
      pin_load <= 1'b0;
      repeat (4) @(posedge clock_in);
   endtask
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc > 5000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      {rst_n_in, read_in, write_in, address_in, writedata_in} = '0;
      {adc_channel_in, latch, pin_val, n_errors, tests_run, cyc} = '0;
      byteenable_in = 4'hf;
      pin_load = 1'b1;
      rnd = 32'hec1d6a0b;
      repeat (6) @(posedge clock_in);
      rst_n_in <= 1'b1;
      for (int a = 0; a <= 'h3c; a += 4) rchk(8'(a), 8'h00);
      chk({31'h0, &gpio_o}, 32'h1);
      $display("reset values test done");
      for (int i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         d = rnd[7:0] & (RW_ADDR[i % 6] == 8'h08 ? 8'h0f : 8'hff);
         bus(1'b1, RW_ADDR[i % 6], d, 4'hf);
         rchk(RW_ADDR[i % 6], d);
      end
      bus(1'b1, 8'h24, ~d, 4'he);
      rchk(8'h24, d);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, UN_ADDR[i], UN_WR[i], 4'hf);
         rchk(UN_ADDR[i], UN_RD[i]);
      end
      $display("register access test done");
      for (int p = 0; p < 6; p++) begin
         for (int c = 0; c < 4; c++) begin
            bus(1'b1, DEC_ADDR[p], 8'(c << DEC_SH[p]), 4'hf);
            repeat (2) @(posedge clock_in);
            chk({29'h0, got_cls(DEC_PIN[p])}, {29'h0, DEC_EXP[p][3*c +: 3]});
         end
         bus(1'b1, DEC_ADDR[p], 8'h00, 4'hf);
      end
      bus(1'b1, 8'h1c, 8'h00, 4'hf);
      $display("pin decode test done");
      for (int k = 0; k < 5; k++) begin
         for (int s = 0; s < 2; s++) begin
            bus(1'b1, RT_ADDR[k], RT_BASE[k] | 8'(s << RT_BIT[k]), 4'hf);
            for (int v = 0; v < 2; v++) begin
               rnd = lfsr(rnd);
               pv = {rnd[23:0], rnd};
               pv[s ? RT_P1[k] : RT_P0[k]] = v[0];
               pv[s ? RT_P0[k] : RT_P1[k]] = ~v[0];
               set_pins(pv);
               chk({31'h0, route_out(k)}, 32'(v));
            end
         end
      end
      $display("input route test done");
      rnd = lfsr(rnd);
      latch <= {rnd[7:0], ~rnd};
      adc_channel_in <= 4'h3;
      set_pins({rnd[23:0], rnd});
      g = gpio_o;
      for (int m = 0; m < 4; m++) begin
         em = KEYS[m] == READ_PORT_KEY;
         bus(1'b1, KEY_OFS, KEYS[m], 4'hf);
         @(posedge clock_in);
         chk({31'h0, mode}, {31'h0, em});
         rchk(KEY_OFS, KEYS[m]);
         for (int k = 0; k < 5; k++) begin
            rchk(PORT_READ_BASE_OFS + 8'(4 * k),
               em ? pins[PIN_C + 8 * k +: 8] : latch[8 * k +: 8]);
         end
         chk({31'h0, gpio_o === g}, 32'h1);
      end
      $display("read port test done");
      report_and_stop();
   end
endmodule
